// ---- rtl/memctl_error_log_regs.sv ----
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module memctl_error_log_regs
   import memctl_log_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [DATA_W-1:0] RDATA,
   output logic IRQ,
   input wire logic LINK_ERR_VALID,
   input wire logic [10:0] LINK_ERR_BUS_CODE,
   input wire logic MC_ERR_VALID,
   input wire logic [2:0] MC_ERR_TXN,
   input wire logic [3:0] MC_ERR_CHANNEL,
   input wire logic [15:0] MC_ERR_MSCOD,
   input wire logic MC_ERR_CORRECTED,
   input wire logic MC_ERR_NORMAL_READ,
   input wire logic [4:0] MC_ERR_DEV_ENC,
   input wire logic [15:0] MC_ERR_DEV_MASK,
   input wire logic [4:0] MC_ERR_DEV_RANK,
   input wire logic [2:0] MC_ERR_DEV_SLOT,
   input wire logic [4:0] MC_ERR_PARITY_INFO
);
   ////////////////////////////////////////////////////////////////////////////
   // Code classification for capture logic; ms_code_legal is shared with the checks
   function automatic logic ms_code_legal(input logic [15:0] c);
      return (c == MS_ADDR_PARITY) || (c == MS_WB_DATA_PARITY) ||
         (c == MS_WR_BE_PARITY) || (c == MS_SCRUB_CORR) ||
         (c == MS_SCRUB_UNCORR) || (c == MS_SPARE_CORR) ||
         (c == MS_SPARE_UNCORR);
   endfunction

   function automatic logic is_wb_parity(input logic [15:0] c);
      return (c == MS_WB_DATA_PARITY) || (c == MS_WR_BE_PARITY);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [63:0] link_q;
   logic [63:0] link_d;
   logic [63:0] mc_status_q;
   logic [63:0] mc_status_d;
   logic [63:0] misc_q;
   logic [63:0] misc_d;
   logic [63:0] log_ctrl_q;
   logic [63:0] log_ctrl_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   event_flag_if #(.N(EVT_N)) evt ();

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   logic wr_link;
   logic wr_status;
   logic wr_detail;
   logic wr_ctrl;
   logic wr_evt_status;
   logic wr_evt_mask;

   assign wr_link = WR_EN && (ADDR == OFS_LINK_STATUS);
   assign wr_status = WR_EN && (ADDR == OFS_MC_STATUS);
   assign wr_detail = WR_EN && (ADDR == OFS_MC_DETAIL);
   assign wr_ctrl = WR_EN && (ADDR == OFS_LOG_CTRL);
   assign wr_evt_status = WR_EN && (ADDR == OFS_EVT_STATUS);
   assign wr_evt_mask = WR_EN && (ADDR == OFS_EVT_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Capture qualifiers
   logic extra_on;
   logic [15:0] mscod;
   logic detail_hit;
   logic take_first;
   logic take_second;
   logic parity_fill;

   assign extra_on = log_ctrl_q[EXTRA_LOG_BIT];
   assign mscod = ms_code_legal(MC_ERR_MSCOD) ? MC_ERR_MSCOD : MS_NONE;
   assign detail_hit = MC_ERR_VALID && extra_on && MC_ERR_CORRECTED &&
      MC_ERR_NORMAL_READ;
   assign take_first = detail_hit && !misc_q[VALID1_BIT];
   // Second record is only filled behind a valid first one
   assign take_second = detail_hit && misc_q[VALID1_BIT] && !misc_q[VALID2_BIT];
   assign parity_fill = MC_ERR_VALID && !extra_on && is_wb_parity(mscod);

   ////////////////////////////////////////////////////////////////////////////
   // Link status word; hardware capture beats a software write in the same cycle
   logic [63:0] link_cap;

   assign link_cap = {48'h0000_0000_0000, 4'h0, 1'b1, LINK_ERR_BUS_CODE};
   assign link_d = LINK_ERR_VALID ? link_cap :
      wr_link ? (WDATA & LINK_WMASK) : link_q;

   ////////////////////////////////////////////////////////////////////////////
   // Controller status word
   logic [15:0] mc_arch;
   logic [4:0] other_d;
   logic [63:0] mc_cap;

   assign mc_arch = {8'h00, 1'b1, MC_ERR_TXN, MC_ERR_CHANNEL};
   // Other-info keeps the first device while that record stays valid
   assign other_d = take_first ? MC_ERR_DEV_ENC :
      misc_q[VALID1_BIT] ? mc_status_q[OTHER_LSB +: 5] : 5'h00;
   assign mc_cap = {27'h000_0000, other_d, mscod, mc_arch};
   assign mc_status_d = MC_ERR_VALID ? mc_cap :
      wr_status ? (WDATA & MC_STATUS_WMASK) : mc_status_q;

   ////////////////////////////////////////////////////////////////////////////
   // Detail word fields
   logic [4:0] dev2_d;
   logic [15:0] mask1_d;
   logic [15:0] mask2_d;
   logic [4:0] rank1_d;
   logic [4:0] rank2_d;
   logic [2:0] slot1_d;
   logic [2:0] slot2_d;
   logic valid1_d;
   logic valid2_d;
   logic [63:0] misc_cap;

   // Bits 13:9 are shared: second device with detail on, parity info otherwise
   assign dev2_d = take_second ? MC_ERR_DEV_ENC :
      parity_fill ? MC_ERR_PARITY_INFO : misc_q[DEV2_LSB +: 5];
   assign mask1_d = take_first ? MC_ERR_DEV_MASK : misc_q[MASK1_LSB +: 16];
   assign mask2_d = take_second ? MC_ERR_DEV_MASK : misc_q[MASK2_LSB +: 16];
   assign rank1_d = take_first ? MC_ERR_DEV_RANK : misc_q[RANK1_LSB +: 5];
   assign slot1_d = take_first ? MC_ERR_DEV_SLOT : misc_q[SLOT1_LSB +: 3];
   assign rank2_d = take_second ? MC_ERR_DEV_RANK : misc_q[RANK2_LSB +: 5];
   assign slot2_d = take_second ? MC_ERR_DEV_SLOT : misc_q[SLOT2_LSB +: 3];
   assign valid1_d = take_first | misc_q[VALID1_BIT];
   assign valid2_d = take_second | misc_q[VALID2_BIT];
   assign misc_cap = {valid2_d, valid1_d, slot2_d, slot1_d, rank2_d, rank1_d,
      mask2_d, mask1_d, dev2_d, 9'h000};
   // Software may clear the records by writing zero; capture still wins
   assign misc_d = MC_ERR_VALID ? misc_cap :
      wr_detail ? (WDATA & MC_DETAIL_WMASK) : misc_q;

   assign log_ctrl_d = wr_ctrl ? (WDATA & LOG_CTRL_WMASK) : log_ctrl_q;

   ////////////////////////////////////////////////////////////////////////////
   // Event flags and interrupt
   assign evt.set_pulse = {take_second, take_first, MC_ERR_VALID, LINK_ERR_VALID};
   assign evt.clear_w1 = wr_evt_status ? WDATA[EVT_N-1:0] : RST_EVT;
   assign evt.mask_wr = wr_evt_mask;
   assign evt.mask_wdata = WDATA[EVT_N-1:0];

   event_flags #(.N(EVT_N)) u_flags (
      .clk(CLK_SYS),
      .rst(RESET),
      .f(evt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero, data valid the cycle after RD_EN
   logic [63:0] rd_mux;

   assign rd_mux = (ADDR == OFS_LINK_STATUS) ? link_q :
      (ADDR == OFS_MC_STATUS) ? mc_status_q :
      (ADDR == OFS_MC_DETAIL) ? misc_q :
      (ADDR == OFS_LOG_CTRL) ? log_ctrl_q :
      (ADDR == OFS_EVT_STATUS) ? {60'h0, evt.status} :
      (ADDR == OFS_EVT_MASK) ? {60'h0, evt.mask} : RST_REG64;
   assign rdata_d = RD_EN ? rd_mux : RST_REG64;

   ////////////////////////////////////////////////////////////////////////////
   // Register update
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         link_q <= RST_REG64;
         mc_status_q <= RST_REG64;
         misc_q <= RST_REG64;
         log_ctrl_q <= RST_REG64;
         rdata_q <= RST_REG64;
      end else begin
         link_q <= link_d;
         mc_status_q <= mc_status_d;
         misc_q <= misc_d;
         log_ctrl_q <= log_ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ = evt.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   sequence s_first_taken;
      take_first;
   endsequence

   sequence s_second_taken;
      take_second;
   endsequence

   a_link_code_form:
      assert property (LINK_ERR_VALID |=> link_q[15:12] == 4'h0 &&
         link_q[LINK_MARK_BIT] && link_q[10:0] == $past(LINK_ERR_BUS_CODE) &&
         link_q[56:16] == 41'h0)
      else $error("link status code not in bus format");

   a_mc_code_form:
      assert property (MC_ERR_VALID |=> mc_status_q[MC_MARK_BIT] &&
         mc_status_q[15:8] == 8'h00 &&
         mc_status_q[6:0] == {$past(MC_ERR_TXN), $past(MC_ERR_CHANNEL)})
      else $error("controller status code not in 1MMMCCCC form");

   a_ms_code_known:
      assert property (MC_ERR_VALID |=> (mc_status_q[31:16] == MS_NONE) ||
         (ms_code_legal(mc_status_q[31:16]) &&
         mc_status_q[31:16] == $past(MC_ERR_MSCOD)))
      else $error("reserved model-specific code stored");

   a_detail_gated:
      assert property (MC_ERR_VALID && !extra_on |=>
         misc_q[63:14] == $past(misc_q[63:14]))
      else $error("detail captured with logging off");

   a_first_other:
      assert property (s_first_taken |=>
         mc_status_q[OTHER_LSB +: 5] == $past(MC_ERR_DEV_ENC))
      else $error("first device code not in status");

   a_parity_slot:
      assert property (parity_fill |=>
         misc_q[DEV2_LSB +: 5] == $past(MC_ERR_PARITY_INFO))
      else $error("parity information not logged");

   a_first_record:
      assert property (s_first_taken |=> misc_q[VALID1_BIT] && !misc_q[VALID2_BIT] &&
         misc_q[MASK1_LSB +: 16] == $past(MC_ERR_DEV_MASK) &&
         misc_q[RANK1_LSB +: 5] == $past(MC_ERR_DEV_RANK) &&
         misc_q[SLOT1_LSB +: 3] == $past(MC_ERR_DEV_SLOT))
      else $error("first device record wrong");

   a_second_record:
      assert property (s_second_taken |=> misc_q[VALID2_BIT] && misc_q[VALID1_BIT] &&
         misc_q[DEV2_LSB +: 5] == $past(MC_ERR_DEV_ENC) &&
         misc_q[MASK2_LSB +: 16] == $past(MC_ERR_DEV_MASK) &&
         misc_q[RANK2_LSB +: 5] == $past(MC_ERR_DEV_RANK) &&
         misc_q[SLOT2_LSB +: 3] == $past(MC_ERR_DEV_SLOT))
      else $error("second device record wrong");

   a_first_frozen:
      assert property (misc_q[VALID1_BIT] && !wr_detail |=> misc_q[VALID1_BIT] &&
         $stable(misc_q[MASK1_LSB +: 16]) && $stable(misc_q[RANK1_LSB +: 5]) &&
         $stable(misc_q[SLOT1_LSB +: 3]))
      else $error("valid first record overwritten");

   a_second_behind_first:
      assert property (misc_q[VALID2_BIT] && !$past(wr_detail) |-> misc_q[VALID1_BIT])
      else $error("second record valid without first");

   a_read_one_cycle:
      assert property (!RD_EN |=> RDATA == RST_REG64)
      else $error("read data outside its cycle");
endmodule

// ---- rtl/memctl_log_pkg.sv ----
package memctl_log_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 64;
   localparam int EVT_N = 4;

   // Register byte offsets, one 64-bit word each
   localparam logic [7:0] OFS_LINK_STATUS = 8'h00;
   localparam logic [7:0] OFS_MC_STATUS = 8'h08;
   localparam logic [7:0] OFS_MC_DETAIL = 8'h10;
   localparam logic [7:0] OFS_LOG_CTRL = 8'h18;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h20;
   localparam logic [7:0] OFS_EVT_MASK = 8'h28;

   // Values after reset
   localparam logic [63:0] RST_REG64 = 64'h0000_0000_0000_0000;
   localparam logic [3:0] RST_EVT = 4'h0;

   // Software-writable bits; the rest read as zero
   localparam logic [63:0] LINK_WMASK = 64'h0000_0000_0000_FFFF;
   localparam logic [63:0] MC_STATUS_WMASK = 64'h0000_001F_FFFF_FFFF;
   localparam logic [63:0] MC_DETAIL_WMASK = 64'hFFFF_FFFF_FFFF_FE00;
   localparam logic [63:0] LOG_CTRL_WMASK = 64'h0000_0000_0000_0002;

   // Field positions
   localparam int EXTRA_LOG_BIT = 1;
   localparam int LINK_MARK_BIT = 11;
   localparam int MC_MARK_BIT = 7;
   localparam int OTHER_LSB = 32;
   localparam int DEV2_LSB = 9;
   localparam int MASK1_LSB = 14;
   localparam int MASK2_LSB = 30;
   localparam int RANK1_LSB = 46;
   localparam int RANK2_LSB = 51;
   localparam int SLOT1_LSB = 56;
   localparam int SLOT2_LSB = 59;
   localparam int VALID1_BIT = 62;
   localparam int VALID2_BIT = 63;

   // Model-specific status codes
   localparam logic [15:0] MS_ADDR_PARITY = 16'h0001;
   localparam logic [15:0] MS_WB_DATA_PARITY = 16'h0002;
   localparam logic [15:0] MS_WR_BE_PARITY = 16'h0004;
   localparam logic [15:0] MS_SCRUB_CORR = 16'h0008;
   localparam logic [15:0] MS_SCRUB_UNCORR = 16'h0010;
   localparam logic [15:0] MS_SPARE_CORR = 16'h0020;
   localparam logic [15:0] MS_SPARE_UNCORR = 16'h0040;
   localparam logic [15:0] MS_NONE = 16'h0000;

   // Event flag positions
   localparam int EVT_LINK = 0;
   localparam int EVT_MC = 1;
   localparam int EVT_FIRST = 2;
   localparam int EVT_SECOND = 3;
endpackage

// ---- rtl/event_flag_if.sv ----
`timescale 1ns/10ps
interface event_flag_if #(parameter int N = 4);
   logic [N-1:0] set_pulse;
   logic [N-1:0] clear_w1;
   logic mask_wr;
   logic [N-1:0] mask_wdata;
   logic [N-1:0] status;
   logic [N-1:0] mask;
   logic irq;

   modport owner (output set_pulse, output clear_w1, output mask_wr, output mask_wdata,
      input status, input mask, input irq);
   modport flags (input set_pulse, input clear_w1, input mask_wr, input mask_wdata,
      output status, output mask, output irq);
endinterface

// ---- rtl/event_flags.sv ----
`timescale 1ns/10ps
module event_flags
   import memctl_log_pkg::*;
#(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic rst,
   event_flag_if.flags f
);
   logic [N-1:0] status_q;
   logic [N-1:0] status_d;
   logic [N-1:0] mask_q;
   logic [N-1:0] mask_d;
   logic irq_q;

   if (N < 1 || N > DATA_W) begin : g_bad_n
      $error("event_flags: N must lie between 1 and the data width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky bits: an event in the clearing cycle must survive, so set wins
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign status_d[i] = f.set_pulse[i] | (status_q[i] & ~f.clear_w1[i]);
   end
   assign mask_d = f.mask_wr ? f.mask_wdata : mask_q;

   // Interrupt follows next-state values so it lines up with the status word
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= N'(RST_EVT);
         mask_q <= N'(RST_EVT);
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q <= mask_d;
         irq_q <= |(status_d & mask_d);
      end
   end

   assign f.status = status_q;
   assign f.mask = mask_q;
   assign f.irq = irq_q;
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
   import memctl_log_pkg::*;
   logic CLK_SYS = 1'b0;
   logic RESET = 1'b1;
   logic [ADDR_W-1:0] ADDR = 8'h00;
   logic [DATA_W-1:0] WDATA = 64'h0;
   logic WR_EN = 1'b0;
   logic RD_EN = 1'b0;
   logic [DATA_W-1:0] RDATA;
   logic IRQ;
   logic LINK_ERR_VALID = 1'b0;
   logic [10:0] LINK_ERR_BUS_CODE = 11'h000;
   logic MC_ERR_VALID = 1'b0;
   logic [2:0] MC_ERR_TXN = 3'h0;
   logic [3:0] MC_ERR_CHANNEL = 4'h0;
   logic [15:0] MC_ERR_MSCOD = 16'h0000;
   logic MC_ERR_CORRECTED = 1'b0;
   logic MC_ERR_NORMAL_READ = 1'b0;
   logic [4:0] MC_ERR_DEV_ENC = 5'h00;
   logic [15:0] MC_ERR_DEV_MASK = 16'h0000;
   logic [4:0] MC_ERR_DEV_RANK = 5'h00;
   logic [2:0] MC_ERR_DEV_SLOT = 3'h0;
   logic [4:0] MC_ERR_PARITY_INFO = 5'h00;
   int n_mismatch = 0;
   int n_tests = 0;

   memctl_error_log_regs i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .IRQ(IRQ),
      .LINK_ERR_VALID(LINK_ERR_VALID), .LINK_ERR_BUS_CODE(LINK_ERR_BUS_CODE),
      .MC_ERR_VALID(MC_ERR_VALID), .MC_ERR_TXN(MC_ERR_TXN), .MC_ERR_CHANNEL(MC_ERR_CHANNEL),
      .MC_ERR_MSCOD(MC_ERR_MSCOD), .MC_ERR_CORRECTED(MC_ERR_CORRECTED),
      .MC_ERR_NORMAL_READ(MC_ERR_NORMAL_READ), .MC_ERR_DEV_ENC(MC_ERR_DEV_ENC),
      .MC_ERR_DEV_MASK(MC_ERR_DEV_MASK), .MC_ERR_DEV_RANK(MC_ERR_DEV_RANK),
      .MC_ERR_DEV_SLOT(MC_ERR_DEV_SLOT), .MC_ERR_PARITY_INFO(MC_ERR_PARITY_INFO));

   // Free-running system clock, 8 ns period
   always #4 CLK_SYS = ~CLK_SYS;

   ////////////////////////////////////////////////////////////////////////////////
   // Shared bus and event helpers
   task chk(input string what, input logic [63:0] e, input logic [63:0] s);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask

   task wr(input logic [7:0] a, input logic [63:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= d;
      WR_EN <= 1'b1;
      @(posedge CLK_SYS);
      WR_EN <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task rd(input logic [7:0] a, input logic [63:0] e);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD_EN <= 1'b1;
      @(posedge CLK_SYS);
      RD_EN <= 1'b0;
      #1;
      chk($sformatf("word at %h", a), e, RDATA);
   endtask

   task mc(input logic c, input logic r, input logic [2:0] t, input logic [3:0] ch,
      input logic [15:0] ms, input logic [4:0] en, input logic [15:0] m,
      input logic [4:0] rk, input logic [2:0] sl, input logic [4:0] p);
      @(posedge CLK_SYS);
      {MC_ERR_CORRECTED, MC_ERR_NORMAL_READ, MC_ERR_TXN, MC_ERR_CHANNEL} <= {c, r, t, ch};
      {MC_ERR_MSCOD, MC_ERR_DEV_ENC, MC_ERR_DEV_MASK} <= {ms, en, m};
      {MC_ERR_DEV_RANK, MC_ERR_DEV_SLOT, MC_ERR_PARITY_INFO} <= {rk, sl, p};
      MC_ERR_VALID <= 1'b1;
      @(posedge CLK_SYS);
      MC_ERR_VALID <= 1'b0;
   endtask

   function automatic logic [63:0] st(logic [2:0] t, logic [3:0] ch, logic [15:0] ms,
      logic [4:0] oi);
      return {27'h0, oi, ms, 8'h00, 1'b1, t, ch};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset;
      for (int i = 0; i < 7; i++) rd(8'(i * 8), 64'h0);
      wr(8'h30, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(8'h30, 64'h0);
      wr(OFS_LINK_STATUS, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(OFS_LINK_STATUS, 64'h0000_0000_0000_FFFF);
      wr(OFS_LINK_STATUS, 64'h0);
   endtask

   // Link error lands with its marker bit, raises the flag and the interrupt
   task t_link;
      wr(OFS_EVT_MASK, 64'h0F);
      @(posedge CLK_SYS);
      LINK_ERR_BUS_CODE <= 11'h2A5;
      LINK_ERR_VALID <= 1'b1;
      @(posedge CLK_SYS);
      LINK_ERR_VALID <= 1'b0;
      rd(OFS_LINK_STATUS, 64'h0000_0000_0000_0AA5);
      rd(OFS_EVT_STATUS, 64'h1);
      chk("irq raised", 64'h1, {63'h0, IRQ});
      wr(OFS_EVT_STATUS, 64'h1);
      rd(OFS_EVT_STATUS, 64'h0);
      chk("irq cleared", 64'h0, {63'h0, IRQ});
   endtask

   // Every model-specific code plus a reserved one, with extra logging off
   task t_codes;
      logic [15:0] cl [8];
      logic [15:0] ms;
      logic [63:0] ed;
      cl = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0100};
      ed = 64'h0;
      for (int i = 0; i < 8; i++) begin
         ms = cl[i];
         mc(1'b1, 1'b1, 3'(i), 4'(15 - i), ms, 5'h1F, 16'hFFFF, 5'h1F, 3'h7, 5'(i + 3));
         if (ms == MS_WB_DATA_PARITY || ms == MS_WR_BE_PARITY) ed = 64'(i + 3) << 9;
         rd(OFS_MC_STATUS, st(3'(i), 4'(15 - i), (i < 7) ? ms : MS_NONE, 5'h0));
         rd(OFS_MC_DETAIL, ed);
      end
   endtask

   // Two device records with extra logging on; first frozen, second filled once
   task t_records;
      logic [63:0] d1;
      logic [63:0] d2;
      wr(OFS_LOG_CTRL, 64'h2);
      wr(OFS_MC_DETAIL, 64'h0);
      wr(OFS_EVT_STATUS, 64'hF);
      mc(1'b0, 1'b1, 3'h1, 4'h2, MS_SCRUB_UNCORR, 5'h13, 16'hBEEF, 5'h0B, 3'h5, 5'h00);
      rd(OFS_MC_DETAIL, 64'h0);
      mc(1'b1, 1'b0, 3'h1, 4'h2, MS_SCRUB_CORR, 5'h13, 16'hBEEF, 5'h0B, 3'h5, 5'h00);
      rd(OFS_MC_DETAIL, 64'h0);
      mc(1'b1, 1'b1, 3'h3, 4'h4, MS_SCRUB_CORR, 5'h13, 16'hBEEF, 5'h0B, 3'h5, 5'h00);
      d1 = (64'hBEEF << 14) | (64'h0B << 46) | (64'h5 << 56) | (64'h1 << 62);
      rd(OFS_MC_STATUS, st(3'h3, 4'h4, MS_SCRUB_CORR, 5'h13));
      rd(OFS_MC_DETAIL, d1);
      rd(OFS_EVT_STATUS, 64'h6);
      mc(1'b1, 1'b1, 3'h2, 4'h9, MS_SPARE_CORR, 5'h07, 16'h1234, 5'h15, 3'h6, 5'h00);
      d2 = d1 | (64'h07 << 9) | (64'h1234 << 30) | (64'h15 << 51) | (64'h6 << 59);
      rd(OFS_MC_DETAIL, d2 | (64'h1 << 63));
      mc(1'b1, 1'b1, 3'h2, 4'h9, MS_SPARE_CORR, 5'h1A, 16'hA5A5, 5'h02, 3'h1, 5'h00);
      rd(OFS_MC_DETAIL, d2 | (64'h1 << 63));
      rd(OFS_EVT_STATUS, 64'hE);
      rd(OFS_LOG_CTRL, 64'h2);
   endtask

   // Masking gates the interrupt per flag
   task t_mask;
      wr(OFS_EVT_MASK, 64'h0);
      rd(OFS_EVT_MASK, 64'h0);
      chk("irq masked", 64'h0, {63'h0, IRQ});
      wr(OFS_EVT_MASK, 64'h8);
      rd(OFS_EVT_STATUS, 64'hE);
      chk("irq unmasked", 64'h1, {63'h0, IRQ});
      wr(OFS_EVT_STATUS, 64'h8);
      rd(OFS_EVT_STATUS, 64'h6);
      chk("irq after clear", 64'h0, {63'h0, IRQ});
   endtask

   // Reset in mid-run with live state; look past the launching edge before judging IRQ
   task t_rst_mid;
      wr(OFS_EVT_MASK, 64'hF);
      #1;
      chk("irq before reset", 64'h1, {63'h0, IRQ});
      @(posedge CLK_SYS);
      RESET <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RESET <= 1'b0;
      #1;
      chk("irq after reset", 64'h0, {63'h0, IRQ});
      for (int i = 0; i < 6; i++) rd(8'(i * 8), 64'h0);
   endtask

   // A flag set and its clear in one cycle: the set must survive, the capture beats nothing
   task t_collide;
      @(posedge CLK_SYS);
      ADDR <= OFS_EVT_STATUS;
      WDATA <= 64'h3;
      WR_EN <= 1'b1;
      LINK_ERR_BUS_CODE <= 11'h155;
      LINK_ERR_VALID <= 1'b1;
      @(posedge CLK_SYS);
      WR_EN <= 1'b0;
      LINK_ERR_VALID <= 1'b0;
      rd(OFS_EVT_STATUS, 64'h1);
      rd(OFS_LINK_STATUS, 64'h0000_0000_0000_0955);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and run control
   task results;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The whole sequence needs well under 1000 cycles; cut a hang at 20000
   initial begin
      #160000;
      n_mismatch++;
      results();
   end

   initial begin
      repeat (12) @(posedge CLK_SYS);
      RESET <= 1'b0;
      t_reset();
      t_link();
      t_codes();
      t_records();
      t_mask();
      t_rst_mid();
      t_collide();
      results();
   end
endmodule
